//--- ifd_pkg.sv
// ifd_pkg: constants, register map and types for the instruction field decoder
// assumes a single pclk domain and an APB slave with 32-bit data
package ifd_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] IFD_CTRL_OFS = 8'h00;
   localparam logic [7:0] IFD_INSN_OFS = 8'h04;
   localparam logic [7:0] IFD_STAT_OFS = 8'h08;
   localparam logic [7:0] IFD_WORKING_REGISTER_OFS = 8'h0c;
   localparam logic [7:0] IFD_TPTR_OFS = 8'h10;
   localparam logic [7:0] IFD_TLAT_OFS = 8'h14;
   localparam logic [7:0] IFD_FLD_OFS = 8'h18;
   localparam logic [7:0] IFD_CORE_OFS = 8'h1c;
   localparam logic [7:0] IFD_FILE_OFS = 8'h20;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int IFD_GLINT_BIT = 4;
   localparam int IFD_FLAG_C = 0;
   localparam int IFD_FLAG_DC = 1;
   localparam int IFD_FLAG_Z = 2;
   localparam int IFD_FLAG_OV = 3;
   localparam logic [7:0] IFD_CORE_RST = 8'h10;
   localparam logic [7:0] IFD_ARITH_RST = 8'h00;
   localparam logic [15:0] IFD_TPTR_RST = 16'h0000;
   localparam logic [1:0] IFD_PHASES = 2'h3;
   localparam logic [7:0] IFD_ARITH_OFS = 8'h04;
   localparam logic [7:0] IFD_CSTA_OFS = 8'h06;
   localparam logic [7:0] IFD_WORKING_REGISTER_FOFS = 8'h0a;
   localparam logic [7:0] IFD_TLATL_FOFS = 8'h0b;
   localparam logic [7:0] IFD_TLATH_FOFS = 8'h0c;

   // instruction classes and operations
   typedef enum {
      IFD_OP_NOP, IFD_OP_MOVWF, IFD_OP_ALU, IFD_OP_CLRSET, IFD_OP_SKIP,
      IFD_OP_MOVPF, IFD_OP_MOVFP, IFD_OP_TBL, IFD_OP_BIT, IFD_OP_LIT,
      IFD_OP_BRANCH, IFD_OP_GLINT, IFD_OP_RSVD
   } ifd_op_t;
   typedef enum {IFD_IDLE, IFD_EXEC, IFD_SECOND} ifd_state_t;
endpackage

//--- ifd_core.sv
// ifd_core: instruction field decoder and two-cycle sequencer
// assumes software feeds words over apb; file memory is a local array
//
// Contract
// RULE_01: each instruction is one 16-bit word, opcode then operand fields.
// RULE_02: 58 instructions in byte, bit and literal/control classes.
// RULE_03: d=0 result to working register, d=1 to the file register.
// RULE_04: destination default encoding is 1, the file register.
// RULE_05: s=0 stores result in file and working register; s=1 file only.
// RULE_06: i=1 increments table pointer after execution, i=0 leaves it.
// RULE_07: t=0 acts on table latch low byte, t=1 on high byte.
// RULE_08: file operand is an 8-bit address 00h to ffh.
// RULE_09: peripheral operand is a 5-bit address 00h to 1fh.
// RULE_10: bit field selects one bit of the 8-bit file register.
// RULE_11: literal is 8-bit or 13-bit depending on instruction.
// RULE_12: unused bit positions must be zero in valid words.
// RULE_13: don't-care bit positions are ignored whatever their value.
// RULE_14: one cycle; second cycle on true test or program counter change.
// RULE_15: table read and write take two cycles, second is a nop.
// RULE_16: an instruction cycle spans four oscillator periods.
// RULE_17: global interrupt disable sits at core status bit 4.
// RULE_18: table pointer is 16 bits wide.
// RULE_19: table latch is 16 bits, high and low bytes separately reached.
// RULE_20: carry, half carry, zero and signed overflow flags kept.
// RULE_21: cycle phases: decode, operand read, process, result write.
// RULE_22: flags produced by an instruction override a write to flags reg.
// RULE_23: undefined opcodes run as one-cycle nop, changing nothing.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module ifd_core
   import ifd_pkg::*;
#(
   parameter int FILE_DEPTH = 256
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic busy,
   output logic [15:0] program_counter
);
   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   if (FILE_DEPTH != 256)
   begin : g_bad_depth
      $error("file depth must cover the full 8-bit address");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   ifd_state_t state_q;
   logic [1:0] phase_q;
   logic [15:0] insn_q;
   logic [7:0] working_register_q;
   logic [15:0] table_pointer_q;
   logic [7:0] table_latch_high_q;
   logic [7:0] table_latch_low_q;
   logic [7:0] core_status_reg_q;
   logic [7:0] arith_flags_reg_q;
   logic [15:0] program_counter_q;
   logic [7:0] file_mem [FILE_DEPTH];
   logic [7:0] oper_q;
   logic [7:0] res_q;
   logic [3:0] nflags_q;
   logic second_q;
   logic tbl_inc_q;
   logic busy_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [7:0] fwin_q;
   ifd_op_t op;

   wire logic wr_acc = psel & penable & pwrite & ~pready_q;
   wire logic rd_acc = psel & penable & ~pwrite & ~pready_q;
   wire logic [7:0] f_addr = insn_q[7:0]; // see RULE_08
   wire logic [4:0] p_addr = insn_q[12:8]; // see RULE_09
   wire logic d_bit = insn_q[8]; // see RULE_04
   wire logic t_bit = insn_q[9];
   wire logic i_bit = insn_q[8];
   wire logic [2:0] b_num = insn_q[10:8]; // see RULE_10
   wire logic [12:0] k_long = insn_q[12:0]; // see RULE_11
   wire logic [7:0] k_byte = insn_q[7:0];

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   // one word, opcode in the upper bits, operands below
   function automatic ifd_op_t decode(input logic [15:0] w); // see RULE_01
      ifd_op_t o;
      o = IFD_OP_RSVD;
      if (w == 16'h0000)
         o = IFD_OP_NOP;
      else if (w[15:8] == 8'h01)
         o = IFD_OP_MOVWF;
      else if (w[15:12] == 4'h0 && w[11:9] != 3'h0)
         o = IFD_OP_ALU; // see RULE_02
      else if (w[15:12] == 4'h1)
         o = IFD_OP_ALU;
      else if (w[15:11] == 5'h05)
         o = IFD_OP_CLRSET;
      else if (w[15:12] == 4'h2)
         o = IFD_OP_ALU;
      else if (w[15:10] == 6'h0c && w[9:8] != 2'h3)
         o = IFD_OP_SKIP;
      else if (w[15:13] == 3'h2)
         o = IFD_OP_MOVPF;
      else if (w[15:13] == 3'h3)
         o = IFD_OP_MOVFP;
      else if (w[15:11] == 5'h15)
         o = IFD_OP_TBL;
      else if (w[15:12] == 4'h8)
         o = IFD_OP_BIT;
      else if (w[15:12] == 4'hb)
         o = IFD_OP_LIT;
      else if (w[15:13] == 3'h6 || w[15:13] == 3'h7)
         o = IFD_OP_BRANCH;
      else if (w[15:8] == 8'h00 && w[7:1] == 7'h03)
         o = IFD_OP_GLINT;
      return o; // see RULE_23
   endfunction

   function automatic logic [7:0] fread(input logic [7:0] a,
      input logic [7:0] w, input logic [7:0] fl, input logic [7:0] cs,
      input logic [7:0] m);
      logic [7:0] v;
      v = m;
      if (a == IFD_WORKING_REGISTER_FOFS)
         v = w;
      else if (a == IFD_ARITH_OFS)
         v = fl;
      else if (a == IFD_CSTA_OFS)
         v = cs;
      return v;
   endfunction

   always_comb
   begin
      op = decode(insn_q);
   end

   // ---------------------------------------------------------------
   // sequencer: four oscillator periods per instruction cycle
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= IFD_IDLE;
         phase_q <= 2'h0;
         second_q <= 1'b0;
         busy_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            IFD_IDLE:
            begin
               if (wr_acc && paddr == IFD_INSN_OFS)
               begin
                  state_q <= IFD_EXEC;
                  phase_q <= 2'h0;
                  busy_q <= 1'b1;
               end
            end
            IFD_EXEC:
            begin
               phase_q <= phase_q + 2'h1; // see RULE_16
               if (phase_q == IFD_PHASES)
               begin
                  state_q <= second_q ? IFD_SECOND : IFD_IDLE;
                  busy_q <= second_q;
               end
               // compare operands directly: res_q is still being formed
               if (phase_q == 2'h2)
                  second_q <= (op == IFD_OP_TBL) || (op == IFD_OP_BRANCH)
                     || (op == IFD_OP_SKIP
                     && oper_q == working_register_q); // see RULE_14
            end
            IFD_SECOND:
            begin
               // second cycle is a forced nop
               phase_q <= phase_q + 2'h1; // see RULE_15
               if (phase_q == IFD_PHASES)
               begin
                  state_q <= IFD_IDLE;
                  second_q <= 1'b0;
                  busy_q <= 1'b0;
               end
            end
            default:
            begin
               state_q <= IFD_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // datapath: q2 read, q3 process, q4 write
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         oper_q <= 8'h00;
         res_q <= 8'h00;
         nflags_q <= 4'h0;
      end
      else if (state_q == IFD_EXEC)
      begin
         if (phase_q == 2'h1) // see RULE_21
            oper_q <= fread(f_addr, working_register_q, arith_flags_reg_q,
               core_status_reg_q, file_mem[f_addr]);
         else if (phase_q == 2'h2)
         begin
            res_q <= oper_q;
            nflags_q <= arith_flags_reg_q[3:0];
            case (op)
               IFD_OP_ALU:
               begin
                  // minimal alu: add working register, keeps all four flags
                  res_q <= 8'(oper_q + working_register_q);
                  nflags_q[IFD_FLAG_C] <= ({1'b0, oper_q}
                     + {1'b0, working_register_q}) > 9'h0ff; // see RULE_20
                  nflags_q[IFD_FLAG_DC] <= ({1'b0, oper_q[3:0]}
                     + {1'b0, working_register_q[3:0]}) > 5'h0f;
                  nflags_q[IFD_FLAG_Z] <= 8'(oper_q + working_register_q)
                     == 8'h00;
                  nflags_q[IFD_FLAG_OV] <= (oper_q[7] == working_register_q[7])
                     && (8'(oper_q + working_register_q) >> 7 != 8'(oper_q[7]));
               end
               IFD_OP_CLRSET:
                  res_q <= insn_q[9] ? 8'hff : 8'h00;
               IFD_OP_SKIP:
                  res_q <= {7'h00, oper_q == working_register_q};
               IFD_OP_BIT:
               begin
                  res_q <= oper_q;
                  res_q[b_num] <= insn_q[11];
               end
               IFD_OP_TBL:
                  res_q <= t_bit ? table_latch_high_q : table_latch_low_q;
               IFD_OP_LIT:
                  res_q <= k_byte;
               default:
                  res_q <= oper_q;
            endcase
         end
      end
   end

   // architectural registers and file memory
   always_ff @(posedge pclk)
   begin
      if (state_q == IFD_EXEC && phase_q == IFD_PHASES)
      begin
         if ((op == IFD_OP_ALU && d_bit) || op == IFD_OP_MOVWF
            || op == IFD_OP_CLRSET || op == IFD_OP_BIT)
            file_mem[f_addr] <= (op == IFD_OP_MOVWF) ? working_register_q
               : res_q; // see RULE_03
         else if (op == IFD_OP_MOVPF)
            file_mem[f_addr] <= file_mem[{3'h0, p_addr}];
         else if (op == IFD_OP_MOVFP)
            file_mem[{3'h0, p_addr}] <= oper_q;
      end
      else if (wr_acc && paddr == IFD_FILE_OFS)
         file_mem[pwdata[15:8]] <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         working_register_q <= 8'h00;
         arith_flags_reg_q <= IFD_ARITH_RST;
         core_status_reg_q <= IFD_CORE_RST;
         table_pointer_q <= IFD_TPTR_RST;
         table_latch_high_q <= 8'h00;
         table_latch_low_q <= 8'h00;
         program_counter_q <= 16'h0000;
         tbl_inc_q <= 1'b0;
      end
      else if (state_q == IFD_EXEC && phase_q == IFD_PHASES)
      begin
         program_counter_q <= program_counter_q + 16'h0001;
         tbl_inc_q <= (op == IFD_OP_TBL) && i_bit;
         if (op == IFD_OP_ALU)
         begin
            // fresh flags beat a write into the flags register
            if (!d_bit)
               working_register_q <= res_q; // see RULE_03
            else if (f_addr == IFD_ARITH_OFS)
               arith_flags_reg_q <= {res_q[7:4], 4'h0};
            arith_flags_reg_q[3:0] <= nflags_q; // see RULE_22
         end
         else if (op == IFD_OP_CLRSET && !insn_q[8])
            working_register_q <= res_q; // see RULE_05
         else if (op == IFD_OP_LIT)
            working_register_q <= res_q;
         else if (op == IFD_OP_GLINT)
            core_status_reg_q[IFD_GLINT_BIT] <= insn_q[0]; // see RULE_17
         else if (op == IFD_OP_TBL)
         begin
            if (t_bit)
               table_latch_high_q <= oper_q; // see RULE_07
            else
               table_latch_low_q <= oper_q; // see RULE_19
         end
         else if (op == IFD_OP_BRANCH)
            program_counter_q <= {3'h0, k_long};
      end
      else if (state_q == IFD_SECOND && phase_q == IFD_PHASES && tbl_inc_q)
      begin
         table_pointer_q <= table_pointer_q + 16'h0001; // see RULE_06
         tbl_inc_q <= 1'b0;
      end
      else if (wr_acc && paddr == IFD_TPTR_OFS)
         table_pointer_q <= pwdata[15:0]; // see RULE_18
      else if (wr_acc && paddr == IFD_WORKING_REGISTER_OFS)
         working_register_q <= pwdata[7:0];
   end

   // ---------------------------------------------------------------
   // apb slave, one wait state
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         insn_q <= 16'h0000;
      else if (wr_acc && paddr == IFD_INSN_OFS && state_q == IFD_IDLE)
         insn_q <= pwdata[15:0]; // see RULE_12 see RULE_13
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         fwin_q <= 8'h00;
      end
      else
      begin
         pready_q <= psel & penable & ~pready_q;
         pslverr_q <= 1'b0;
         if (wr_acc && paddr == IFD_CTRL_OFS)
            fwin_q <= pwdata[7:0];
         if (rd_acc)
         begin
            prdata_q <= 32'h0000_0000;
            if (paddr == IFD_CTRL_OFS)
               prdata_q <= {24'h0, fwin_q};
            else if (paddr == IFD_INSN_OFS)
               prdata_q <= {16'h0, insn_q};
            else if (paddr == IFD_STAT_OFS)
               prdata_q <= {27'h0, arith_flags_reg_q[3:0],
                  state_q != IFD_IDLE};
            else if (paddr == IFD_WORKING_REGISTER_OFS)
               prdata_q <= {24'h0, working_register_q};
            else if (paddr == IFD_TPTR_OFS)
               prdata_q <= {16'h0, table_pointer_q};
            else if (paddr == IFD_TLAT_OFS)
               prdata_q <= {16'h0, table_latch_high_q, table_latch_low_q};
            else if (paddr == IFD_FLD_OFS)
               prdata_q <= {11'h0, p_addr, f_addr, 5'h0, b_num};
            else if (paddr == IFD_CORE_OFS)
               prdata_q <= {24'h0, core_status_reg_q};
            else if (paddr == IFD_FILE_OFS)
               prdata_q <= {24'h0, file_mem[fwin_q]};
            else
               pslverr_q <= 1'b1;
         end
         else if (wr_acc && (paddr > IFD_FILE_OFS || paddr[1:0] != 2'h0))
            pslverr_q <= 1'b1;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign busy = busy_q;
   assign program_counter = program_counter_q;
endmodule // ifd_core

//--- ifd_core_monitor.sv
// ifd_core_monitor: port assertions for the instruction field decoder
// assumes one pclk domain; bound to every ifd_core below
`timescale 1ns/1ps
module ifd_core_monitor
   import ifd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic busy,
   input wire logic [15:0] program_counter
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----
   // run length of the last accepted word
   // ----
   logic took;
   logic [1:0] kind_q;
   logic [3:0] run_q;
   assign took = psel && penable && !pready && pwrite && !busy
      && paddr == IFD_INSN_OFS;
   sequence insn_taken;
      took;
   endsequence
   // 1 literal or nop, 2 table or branch, 0 untracked (skips vary)
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         kind_q <= 2'h0;
      else if (took)
         kind_q <= (pwdata[15:11] == 5'h15 || pwdata[15:14] == 2'h3) ? 2'h2
            : (pwdata[15:12] == 4'hb || pwdata[15:0] == 16'h0) ? 2'h1 : 2'h0;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_q <= 4'h0;
      else
         run_q <= busy ? run_q + 4'h1 : 4'h0;
   end
   property branch_lands;
      logic [12:0] k;
      insn_taken ##0 (pwdata[15:14] == 2'h3, k = pwdata[12:0])
         |-> ##[1:12] program_counter == {3'h0, k};
   endproperty
   // ----
   // assertions
   // ----
   a_ready_wait: assert property (psel && penable && !pready |=> pready) // bus
      else $error("pready missing one cycle into access");
   a_ready_access: assert property (pready |-> psel && penable) // bus
      else $error("pready outside access phase");
   a_ready_pulse: assert property (pready |=> !pready) // bus
      else $error("pready held longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready) // bus
      else $error("pslverr without pready");
   a_unmapped_err: assert property (pready && paddr > IFD_FILE_OFS |-> pslverr)
      else $error("unmapped access not refused");
   a_busy_start: assert property (insn_taken |-> ##[1:2] busy)
      else $error("accepted word did not start execution");
   a_short_run: assert property ($fell(busy) && kind_q == 2'h1 |-> run_q == 4'h4)
      else $error("single cycle instruction not four periods");
   a_long_run: assert property ($fell(busy) && kind_q == 2'h2 |-> run_q == 4'h8)
      else $error("two cycle instruction not eight periods");
   a_branch_target: assert property (branch_lands)
      else $error("branch did not load the 13-bit literal");
   a_pc_quiet: assert property ((!busy && !pready)[*4] |-> $stable(program_counter))
      else $error("program counter moved while idle");
endmodule // ifd_core_monitor
bind ifd_core ifd_core_monitor u_ifd_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .busy(busy),
   .program_counter(program_counter)
);

//--- ifd_prog_rom.sv
// ifd_prog_rom: program memory model feeding instruction words
// assumes the fetch address is the core program counter
`timescale 1ns/1ps
module ifd_prog_rom
   import ifd_pkg::*;
(
   input wire logic [15:0] fetch_addr,
   output logic [15:0] fetch_word
);
   // ----
   // stored program
   // ----
   // unprogrammed words read as a changing fill so a stray fetch shows
   always_comb
   begin
      case (fetch_addr)
         16'h0000: fetch_word = 16'hb580;
         16'h0001: fetch_word = 16'h0e50;
         16'h0002: fetch_word = 16'hc123;
         16'h0123: fetch_word = 16'h00f0;
         default: fetch_word = ~fetch_addr;
      endcase
   end
endmodule // ifd_prog_rom

//--- tb_instruction_field_decoder.sv
// tb_instruction_field_decoder: apb driven tests of ifd_core
// assumes ifd_core_monitor is bound in by its own file
`timescale 1ns/1ps
module tb_instruction_field_decoder
   import ifd_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic busy;
   logic [15:0] program_counter;
   logic [15:0] fetch_word;
   logic rdy_n;
   logic err_n;
   logic bsy_n;
   logic [31:0] rd_n;
   int err_total = 0;
   int checked = 0;
   int run_len = 0;
   always #12.5 pclk = ~pclk;
   // outputs copied mid-cycle, so edge tests never race the design
   always @(negedge pclk)
   begin
      rdy_n = pready;
      err_n = pslverr;
      bsy_n = busy;
      rd_n = prdata;
   end
   ifd_core #(.FILE_DEPTH(256)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .busy(busy),
      .program_counter(program_counter)
   );
   ifd_prog_rom u_rom (.fetch_addr(program_counter), .fetch_word(fetch_word));
   // ----
   // tasks
   // ----
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] want);
      checked++;
      if (seen !== want)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (rdy_n !== 1'b1 && n < 20);
      chk("pready", {31'h0, rdy_n}, 32'h1);
      r = rd_n;
      e = err_n;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input string what, input logic [7:0] a,
      input logic [31:0] want);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(what, r, want);
   endtask
   task automatic exec(input logic [15:0] w);
      int n;
      n = 0;
      wr(IFD_INSN_OFS, {16'h0, w});
      repeat (2) @(posedge pclk);
      while (bsy_n !== 1'b0 && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
      run_len = n + 2;
      chk("busy end", {31'h0, bsy_n}, 32'h0);
   endtask
   task automatic fx;
      @(negedge pclk);
      exec(fetch_word);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (6000) @(posedge pclk);
      err_total++;
      tally_and_finish;
   end
   // ----
   // tests
   // ----
   initial
   begin
      logic [31:0] r;
      logic e;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc("core status", IFD_CORE_OFS, {24'h0, IFD_CORE_RST});
      rdc("table ptr", IFD_TPTR_OFS, 32'h0);
      $display("test reset done");
      wr(IFD_FILE_OFS, 32'h5080);
      fx;
      fx;
      rdc("working_register add", IFD_WORKING_REGISTER_OFS, 32'h0);
      wr(IFD_CTRL_OFS, 32'h50);
      rdc("file kept", IFD_FILE_OFS, 32'h80);
      rdc("flags", IFD_STAT_OFS, 32'h1a);
      fx;
      chk("branch pc", {16'h0, program_counter}, 32'h123);
      fx;
      rdc("nop working_register", IFD_WORKING_REGISTER_OFS, 32'h0);
      rdc("nop flags", IFD_STAT_OFS, 32'h1a);
      chk("nop pc", {16'h0, program_counter}, 32'h124);
      $display("test fetched program done");
      exec(16'hbfa5);
      rdc("literal", IFD_WORKING_REGISTER_OFS, 32'ha5);
      wr(IFD_FILE_OFS, 32'h3144);
      wr(IFD_CTRL_OFS, 32'h31);
      exec(16'h2831);
      rdc("clear both", IFD_WORKING_REGISTER_OFS, 32'h0);
      rdc("clear file", IFD_FILE_OFS, 32'h0);
      exec(16'hb5a5);
      exec(16'h2b31);
      rdc("set file", IFD_FILE_OFS, 32'hff);
      rdc("set only", IFD_WORKING_REGISTER_OFS, 32'ha5);
      wr(IFD_FILE_OFS, 32'hff01);
      wr(IFD_CTRL_OFS, 32'hff);
      exec(16'h0fff);
      rdc("add to ff", IFD_FILE_OFS, 32'ha6);
      rdc("working_register kept", IFD_WORKING_REGISTER_OFS, 32'ha5);
      $display("test destinations done");
      exec(16'h0006);
      rdc("irq enabled", IFD_CORE_OFS, 32'h0);
      exec(16'h0007);
      rdc("irq disabled", IFD_CORE_OFS, 32'h10);
      wr(IFD_FILE_OFS, 32'h405a);
      exec(16'haf40);
      rdc("latch high", IFD_TLAT_OFS, 32'h5a00);
      rdc("ptr step", IFD_TPTR_OFS, 32'h1);
      exec(16'hac40);
      rdc("latch low", IFD_TLAT_OFS, 32'h5a5a);
      rdc("ptr held", IFD_TPTR_OFS, 32'h1);
      $display("test table and irq done");
      wr(IFD_INSN_OFS, 32'hb577);
      exec(16'hb588);
      rdc("busy refuse", IFD_WORKING_REGISTER_OFS, 32'h77);
      exec(16'h3150);
      chk("skip false", run_len, 4);
      exec(16'hb580);
      exec(16'h3150);
      chk("skip true", run_len, 8);
      apb(1'b0, 8'h24, 32'h0, r, e);
      chk("unmapped err", {31'h0, e}, 32'h1);
      $display("test refusals done");
      tally_and_finish;
   end
endmodule // tb_instruction_field_decoder
